// file: shared/ptid_defines.vh
// Register map, field positions and reset values of the target image decoder.
// Included by every design file of the block; definitions only.
`ifndef PTID_DEFINES_VH
`define PTID_DEFINES_VH

// Byte addresses on the register bus
`define PTID_OFS_IMG0_CTL 12'h100
`define PTID_OFS_IMG0_ADDR 12'h104
`define PTID_OFS_IMG1_CTL 12'h110
`define PTID_OFS_IMG1_ADDR 12'h114
`define PTID_OFS_MISC 12'h120
`define PTID_OFS_STATUS 12'h124
`define PTID_ADDR_W 12

// Control register fields
`define PTID_CTL_EN 31
`define PTID_CTL_BS_LSB 24
`define PTID_CTL_PREFETCH_READ_ENABLE 23
`define PTID_CTL_BRST 22
`define PTID_CTL_ENDIAN_INVERT 19
`define PTID_CTL_TC_LSB 12
`define PTID_CTL_WIDTH_LSB 10
`define PTID_CTL_POSTED_WRITE_ENABLE 7
`define PTID_CTL_SPACE 6

// Address register fields
`define PTID_ADR_BASE_LSB 16
`define PTID_ADR_TRANS_LSB 0

// Misc control and status fields
`define PTID_MISC_ORDER 0
`define PTID_STAT_STRAP 0
`define PTID_STAT_LOADED0 1
`define PTID_STAT_LOADED1 2
`define PTID_STAT_CFGEN0 3
`define PTID_STAT_CFGEN1 4

// Reset values
`define PTID_RST_BIT 1'b0
`define PTID_RST_BS 4'h0
`define PTID_RST_TC 4'h0
`define PTID_RST_WIDTH 2'h0
`define PTID_RST_HALF 16'h0000
`define PTID_RST_WORD 32'h00000000

// Window sizing: lowest compared line, full upper mask
`define PTID_WIN_LSB 16
`define PTID_MASK_ALL 16'hffff

// Local port width codes
`define PTID_WIDTH_32 2'h0
`define PTID_WIDTH_8 2'h1
`define PTID_WIDTH_16 2'h2

// Bus responses
`define PTID_RESP_OKAY 2'h0
`define PTID_RESP_SLVERR 2'h2

`endif

// file: rtl/ptid_decode.v
// Address compare and translate for one target image.
// Purely combinational; the top registers the results.
`timescale 1ns/1ps
`default_nettype none
`include "ptid_defines.vh"

module ptid_decode (
  // Image settings
  input wire enable,
  input wire spaceIo,
  input wire [3:0] windowSizeCode,
  input wire [15:0] baseAddr,
  input wire [15:0] transAddr,
  // Access
  input wire [31:0] pciAddr,
  input wire accessIo,
  // Result
  output wire hit,
  output wire [31:0] localAddr
);

  wire [15:0] cmpMask;
  wire [15:0] upper;

  assign cmpMask = `PTID_MASK_ALL << windowSizeCode;
  assign upper = pciAddr[31:`PTID_WIN_LSB];
  assign hit = enable && (spaceIo == accessIo) && (((upper ^ baseAddr) & cmpMask) == 16'h0000);
  assign localAddr = {(transAddr & cmpMask) | (upper & ~cmpMask), pciAddr[15:0]};

endmodule
`default_nettype wire

// file: rtl/ptid_image_regs.v
// Control and address registers of one target image.
// Assumes write strobes arrive one cycle each from the bus slave.
`timescale 1ns/1ps
`default_nettype none
`include "ptid_defines.vh"

module ptid_image_regs (
  // Clock and reset
  input wire sys_clk,
  input wire reset_n,
  // Register writes
  input wire wrCtl,
  input wire wrAddr,
  input wire [31:0] wrData,
  input wire [3:0] wrStrb,
  // Preload and straps
  input wire eeLoadDone,
  input wire eeLoaded,
  input wire [3:0] eeWindowSizeCode,
  input wire eeSpace,
  input wire eeCfgBaseEn,
  input wire strapHigh,
  input wire [15:0] cfgBase,
  input wire cfgSpace,
  // Field values
  output wire [31:0] ctlRead,
  output wire [31:0] addrRead,
  output wire loaded,
  output wire cfgBaseOn,
  output wire enable,
  output wire [3:0] windowSizeCode,
  output wire prefetchEn,
  output wire burstEn,
  output wire endianInvert,
  output wire [3:0] transCode,
  output wire [1:0] portWidth,
  output wire postedEn,
  output wire spaceIo,
  output wire [15:0] baseAddr,
  output wire [15:0] transAddr
);

  reg en_r, prefetch_read_enable_r, brst_r, inv_r, posted_write_enable_r, space_r, loaded_r, eeCfg_r;
  reg [3:0] bs_r, tc_r;
  reg [1:0] width_r;
  reg [15:0] base_r, trans_r;
  wire sizeWritable;

  // Strap overrides the preload lock
  assign sizeWritable = !loaded_r || strapHigh;
  assign cfgBaseOn = eeCfg_r || strapHigh;

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      en_r <= `PTID_RST_BIT;
      prefetch_read_enable_r <= `PTID_RST_BIT;
      brst_r <= `PTID_RST_BIT;
      inv_r <= `PTID_RST_BIT;
      posted_write_enable_r <= `PTID_RST_BIT;
      space_r <= `PTID_RST_BIT;
      bs_r <= `PTID_RST_BS;
      tc_r <= `PTID_RST_TC;
      width_r <= `PTID_RST_WIDTH;
      base_r <= `PTID_RST_HALF;
      trans_r <= `PTID_RST_HALF;
      loaded_r <= `PTID_RST_BIT;
      eeCfg_r <= `PTID_RST_BIT;
    end else begin
      if (eeLoadDone) begin
        loaded_r <= eeLoaded;
        eeCfg_r <= eeCfgBaseEn;
        if (eeLoaded) begin
          bs_r <= eeWindowSizeCode;
          space_r <= eeSpace;
        end
      end else if (wrCtl) begin
        if (wrStrb[3]) begin
          en_r <= wrData[`PTID_CTL_EN];
          if (sizeWritable) begin
            bs_r <= wrData[`PTID_CTL_BS_LSB+3:`PTID_CTL_BS_LSB];
          end
        end
        if (wrStrb[2]) begin
          prefetch_read_enable_r <= wrData[`PTID_CTL_PREFETCH_READ_ENABLE];
          brst_r <= wrData[`PTID_CTL_BRST];
          inv_r <= wrData[`PTID_CTL_ENDIAN_INVERT];
        end
        if (wrStrb[1]) begin
          tc_r <= wrData[`PTID_CTL_TC_LSB+3:`PTID_CTL_TC_LSB];
          width_r <= wrData[`PTID_CTL_WIDTH_LSB+1:`PTID_CTL_WIDTH_LSB];
        end
        if (wrStrb[0]) begin
          posted_write_enable_r <= wrData[`PTID_CTL_POSTED_WRITE_ENABLE];
          if (sizeWritable) begin
            space_r <= wrData[`PTID_CTL_SPACE];
          end
        end
      end
      if (wrAddr) begin
        if (!cfgBaseOn && wrStrb[3]) begin
          base_r[15:8] <= wrData[31:24];
        end
        if (!cfgBaseOn && wrStrb[2]) begin
          base_r[7:0] <= wrData[23:16];
        end
        if (wrStrb[1]) begin
          trans_r[15:8] <= wrData[15:8];
        end
        if (wrStrb[0]) begin
          trans_r[7:0] <= wrData[7:0];
        end
      end
    end
  end

  assign loaded = loaded_r;
  assign enable = en_r;
  assign windowSizeCode = bs_r;
  assign prefetchEn = prefetch_read_enable_r;
  assign burstEn = brst_r;
  assign endianInvert = inv_r;
  assign transCode = tc_r;
  assign portWidth = width_r;
  assign postedEn = posted_write_enable_r;
  // Locked preload mirrors the config base space bit
  assign spaceIo = (loaded_r && !strapHigh) ? cfgSpace : space_r;
  assign baseAddr = cfgBaseOn ? cfgBase : base_r;
  assign transAddr = trans_r;

  assign ctlRead = {en_r, 3'h0, bs_r, prefetch_read_enable_r, brst_r, 2'h0, inv_r, 3'h0,
                    tc_r, width_r, 2'h0, posted_write_enable_r, spaceIo, 6'h00};
  assign addrRead = {baseAddr, trans_r};

endmodule
`default_nettype wire

// file: rtl/ptid_top.v
// Target image decoder: two images, AXI4-Lite register slave, and the
// registered decode of PCI address phases onto the local processor bus.
// Assumes the PCI side presents one address phase per valid pulse and
// the serial EEPROM loader pulses eeLoadDone once after reset.
`timescale 1ns/1ps
`default_nettype none
`include "ptid_defines.vh"

// Notes on behaviour
// - Each image has an enable bit; clear claims nothing; resets to zero.
// - Window size is 64 Kbyte times two to the size code.
// - Compared lines run from bit 31 down to bit 16 plus code.
// - Each address phase compares upper lines against the base field.
// - On a hit, compared lines are replaced by translation bits.
// - Prefetch read enable permits prefetching reads; resets to zero.
// - Burst write enable allows burst writes; resets to zero.
// - Endian invert flips the global local bus byte order.
// - Image drives transaction code and port width code onto local cycles.
// - Posted writes only when enabled and only in memory space.
// - Space bit zero selects memory, one selects I/O.
// - Preloaded size and space come from EEPROM, read only, space mirrored.
// - Not preloaded, size and space reset to zero and are writable.
// - Disable strap high at reset makes size and space writable.
// - EEPROM bit or strap makes base read only, tracking config base.
// - Otherwise base is fully writable, independent, zero after reset.
// - Translation field is writable and resets to zero always.
// - A second image has the same control fields.
module ptid_top (
  // Clock and reset
  input wire sys_clk,
  input wire reset_n,
  // AXI4-Lite write address
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // AXI4-Lite write response
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // AXI4-Lite read data
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  // Power-up strap
  input wire pciDisableStrap,
  // Serial EEPROM preload
  input wire eeLoadDone,
  input wire eeLoaded0,
  input wire [3:0] eeWindowSizeCode0,
  input wire eeSpace0,
  input wire eeCfgBaseEn0,
  input wire eeLoaded1,
  input wire [3:0] eeWindowSizeCode1,
  input wire eeSpace1,
  input wire eeCfgBaseEn1,
  // PCI configuration base registers
  input wire [15:0] pciConfigBase0,
  input wire pciConfigSpace0,
  input wire [15:0] pciConfigBase1,
  input wire pciConfigSpace1,
  // PCI address phase
  input wire pciAddrValid,
  input wire [31:0] pciAddr,
  input wire pciAccessIo,
  input wire pciAccessWrite,
  // Decode result
  output wire pciClaim,
  output wire localValid,
  output wire localImage,
  output wire [31:0] localAddr,
  output wire [3:0] localTransCode,
  output wire [1:0] localPortWidth,
  output wire localBigEndian,
  output wire localPrefetch,
  output wire localBurstOk,
  output wire localPosted
);

  // Bus slave state
  reg awReady_r, wReady_r, bValid_r, arReady_r, rValid_r;
  reg awHeld_r, wHeld_r;
  reg [1:0] bResp_r, rResp_r;
  reg [31:0] rData_r;
  reg [11:0] wrAddr_r;
  reg [31:0] wrData_r;
  reg [3:0] wrStrb_r;

  // Strap capture and global settings
  reg strapCaught_r, strapHigh_r;
  reg byteOrder_r;

  // Decode outputs
  reg claim_r, valid_r, image_r, bigEnd_r, pref_r, burst_r, posted_r;
  reg [31:0] localAddr_r;
  reg [3:0] tc_r;
  reg [1:0] width_r;

  // Handshake terms
  wire awTake, wTake, bDone, arTake, rDone;
  wire doWrite;
  wire awHeld_nxt, wHeld_nxt, bValid_nxt, rValid_nxt;
  wire wrHitCtl0, wrHitAddr0, wrHitCtl1, wrHitAddr1, wrHitMisc;
  wire wrMapped;

  // Image fields
  wire [31:0] ctlRead0, addrRead0, ctlRead1, addrRead1;
  wire loaded0, loaded1, cfgOn0, cfgOn1;
  wire en0, en1, pren0, pren1, brst0, brst1, inv0, inv1;
  wire pwen0, pwen1, io0, io1;
  wire [3:0] bs0, bs1, tc0, tc1;
  wire [1:0] pw0, pw1;
  wire [15:0] base0, base1, trans0, trans1;
  wire hit0, hit1;
  wire [31:0] xAddr0, xAddr1;

  // Read mux
  reg [31:0] rdMux;
  reg rdOk;
  wire [31:0] statusWord;

  assign awTake = s_axi_awvalid && awReady_r;
  assign wTake = s_axi_wvalid && wReady_r;
  assign bDone = bValid_r && s_axi_bready;
  assign arTake = s_axi_arvalid && arReady_r;
  assign rDone = rValid_r && s_axi_rready;

  // Write happens once both halves are held and no response is waiting
  assign doWrite = awHeld_r && wHeld_r && !bValid_r;
  assign awHeld_nxt = (awHeld_r && !doWrite) || awTake;
  assign wHeld_nxt = (wHeld_r && !doWrite) || wTake;
  assign bValid_nxt = (bValid_r && !bDone) || doWrite;
  assign rValid_nxt = (rValid_r && !rDone) || arTake;

  assign wrHitCtl0 = doWrite && (wrAddr_r == `PTID_OFS_IMG0_CTL);
  assign wrHitAddr0 = doWrite && (wrAddr_r == `PTID_OFS_IMG0_ADDR);
  assign wrHitCtl1 = doWrite && (wrAddr_r == `PTID_OFS_IMG1_CTL);
  assign wrHitAddr1 = doWrite && (wrAddr_r == `PTID_OFS_IMG1_ADDR);
  assign wrHitMisc = doWrite && (wrAddr_r == `PTID_OFS_MISC);
  assign wrMapped = wrHitCtl0 || wrHitAddr0 || wrHitCtl1 || wrHitAddr1 || wrHitMisc ||
                    (wrAddr_r == `PTID_OFS_STATUS);

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      awReady_r <= 1'b0;
      wReady_r <= 1'b0;
      bValid_r <= 1'b0;
      bResp_r <= `PTID_RESP_OKAY;
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
      wrAddr_r <= 12'h000;
      wrData_r <= `PTID_RST_WORD;
      wrStrb_r <= 4'h0;
    end else begin
      awHeld_r <= awHeld_nxt;
      wHeld_r <= wHeld_nxt;
      bValid_r <= bValid_nxt;
      // Ready stays low while a half is held, so payloads never overrun
      awReady_r <= !awHeld_nxt;
      wReady_r <= !wHeld_nxt;
      if (awTake) begin
        wrAddr_r <= {s_axi_awaddr[11:2], 2'h0};
      end
      if (wTake) begin
        wrData_r <= s_axi_wdata;
        wrStrb_r <= s_axi_wstrb;
      end
      if (doWrite) begin
        bResp_r <= wrMapped ? `PTID_RESP_OKAY : `PTID_RESP_SLVERR;
      end
    end
  end

  // Global byte order lives in the misc control register
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      byteOrder_r <= `PTID_RST_BIT;
    end else if (wrHitMisc && wrStrb_r[0]) begin
      byteOrder_r <= wrData_r[`PTID_MISC_ORDER];
    end
  end

  // Strap is caught on the first edge after reset release
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      strapCaught_r <= 1'b0;
      strapHigh_r <= 1'b0;
    end else if (!strapCaught_r) begin
      strapCaught_r <= 1'b1;
      strapHigh_r <= pciDisableStrap;
    end
  end

  // Image 0
  ptid_image_regs u_regs0 (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .wrCtl(wrHitCtl0),
    .wrAddr(wrHitAddr0),
    .wrData(wrData_r),
    .wrStrb(wrStrb_r),
    .eeLoadDone(eeLoadDone),
    .eeLoaded(eeLoaded0),
    .eeWindowSizeCode(eeWindowSizeCode0),
    .eeSpace(eeSpace0),
    .eeCfgBaseEn(eeCfgBaseEn0),
    .strapHigh(strapHigh_r),
    .cfgBase(pciConfigBase0),
    .cfgSpace(pciConfigSpace0),
    .ctlRead(ctlRead0),
    .addrRead(addrRead0),
    .loaded(loaded0),
    .cfgBaseOn(cfgOn0),
    .enable(en0),
    .windowSizeCode(bs0),
    .prefetchEn(pren0),
    .burstEn(brst0),
    .endianInvert(inv0),
    .transCode(tc0),
    .portWidth(pw0),
    .postedEn(pwen0),
    .spaceIo(io0),
    .baseAddr(base0),
    .transAddr(trans0)
  );

  // Image 1 has the same fields
  ptid_image_regs u_regs1 (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .wrCtl(wrHitCtl1),
    .wrAddr(wrHitAddr1),
    .wrData(wrData_r),
    .wrStrb(wrStrb_r),
    .eeLoadDone(eeLoadDone),
    .eeLoaded(eeLoaded1),
    .eeWindowSizeCode(eeWindowSizeCode1),
    .eeSpace(eeSpace1),
    .eeCfgBaseEn(eeCfgBaseEn1),
    .strapHigh(strapHigh_r),
    .cfgBase(pciConfigBase1),
    .cfgSpace(pciConfigSpace1),
    .ctlRead(ctlRead1),
    .addrRead(addrRead1),
    .loaded(loaded1),
    .cfgBaseOn(cfgOn1),
    .enable(en1),
    .windowSizeCode(bs1),
    .prefetchEn(pren1),
    .burstEn(brst1),
    .endianInvert(inv1),
    .transCode(tc1),
    .portWidth(pw1),
    .postedEn(pwen1),
    .spaceIo(io1),
    .baseAddr(base1),
    .transAddr(trans1)
  );

  ptid_decode u_dec0 (
    .enable(en0),
    .spaceIo(io0),
    .windowSizeCode(bs0),
    .baseAddr(base0),
    .transAddr(trans0),
    .pciAddr(pciAddr),
    .accessIo(pciAccessIo),
    .hit(hit0),
    .localAddr(xAddr0)
  );

  ptid_decode u_dec1 (
    .enable(en1),
    .spaceIo(io1),
    .windowSizeCode(bs1),
    .baseAddr(base1),
    .transAddr(trans1),
    .pciAddr(pciAddr),
    .accessIo(pciAccessIo),
    .hit(hit1),
    .localAddr(xAddr1)
  );

  // Address phase result, one cycle later; image 0 wins an overlap
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      claim_r <= 1'b0;
      valid_r <= 1'b0;
      image_r <= 1'b0;
      localAddr_r <= `PTID_RST_WORD;
      tc_r <= `PTID_RST_TC;
      width_r <= `PTID_RST_WIDTH;
      bigEnd_r <= 1'b0;
      pref_r <= 1'b0;
      burst_r <= 1'b0;
      posted_r <= 1'b0;
    end else begin
      claim_r <= pciAddrValid && (hit0 || hit1);
      valid_r <= pciAddrValid && (hit0 || hit1);
      if (pciAddrValid && hit0) begin
        image_r <= 1'b0;
        localAddr_r <= xAddr0;
        tc_r <= tc0;
        width_r <= pw0;
        bigEnd_r <= byteOrder_r ^ inv0;
        pref_r <= pren0 && !pciAccessWrite;
        burst_r <= brst0 && pciAccessWrite;
        posted_r <= pwen0 && pciAccessWrite && !pciAccessIo;
      end else if (pciAddrValid && hit1) begin
        image_r <= 1'b1;
        localAddr_r <= xAddr1;
        tc_r <= tc1;
        width_r <= pw1;
        bigEnd_r <= byteOrder_r ^ inv1;
        pref_r <= pren1 && !pciAccessWrite;
        burst_r <= brst1 && pciAccessWrite;
        posted_r <= pwen1 && pciAccessWrite && !pciAccessIo;
      end
    end
  end

  assign statusWord = {27'h0000000, cfgOn1, cfgOn0, loaded1, loaded0, strapHigh_r};

  // Read decode on the address as it is taken
  always @* begin
    rdMux = `PTID_RST_WORD;
    rdOk = 1'b1;
    case ({s_axi_araddr[11:2], 2'h0})
      `PTID_OFS_IMG0_CTL: rdMux = ctlRead0;
      `PTID_OFS_IMG0_ADDR: rdMux = addrRead0;
      `PTID_OFS_IMG1_CTL: rdMux = ctlRead1;
      `PTID_OFS_IMG1_ADDR: rdMux = addrRead1;
      `PTID_OFS_MISC: rdMux = {31'h00000000, byteOrder_r};
      `PTID_OFS_STATUS: rdMux = statusWord;
      default: rdOk = 1'b0;
    endcase
  end

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      arReady_r <= 1'b0;
      rValid_r <= 1'b0;
      rData_r <= `PTID_RST_WORD;
      rResp_r <= `PTID_RESP_OKAY;
    end else begin
      rValid_r <= rValid_nxt;
      // One read at a time: no new address until the data is taken
      arReady_r <= !rValid_nxt;
      if (arTake) begin
        rData_r <= rdMux;
        rResp_r <= rdOk ? `PTID_RESP_OKAY : `PTID_RESP_SLVERR;
      end
    end
  end

  assign s_axi_awready = awReady_r;
  assign s_axi_wready = wReady_r;
  assign s_axi_bvalid = bValid_r;
  assign s_axi_bresp = bResp_r;
  assign s_axi_arready = arReady_r;
  assign s_axi_rvalid = rValid_r;
  assign s_axi_rdata = rData_r;
  assign s_axi_rresp = rResp_r;
  assign pciClaim = claim_r;
  assign localValid = valid_r;
  assign localImage = image_r;
  assign localAddr = localAddr_r;
  assign localTransCode = tc_r;
  assign localPortWidth = width_r;
  assign localBigEndian = bigEnd_r;
  assign localPrefetch = pref_r;
  assign localBurstOk = burst_r;
  assign localPosted = posted_r;

endmodule
`default_nettype wire

// file: dv/ptid_checker.sv
// Port assertions for the target image decoder.
// Bound to ptid_top; one clock, asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module ptid_checker (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Address phase
  input wire logic pciAddrValid,
  input wire logic [31:0] pciAddr,
  input wire logic pciAccessIo,
  input wire logic pciAccessWrite,
  // Decode result
  input wire logic pciClaim,
  input wire logic localValid,
  input wire logic [31:0] localAddr,
  input wire logic localPrefetch,
  input wire logic localBurstOk,
  input wire logic localPosted
);
  default clocking dc @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  sequence sAwTaken;
    s_axi_awvalid && s_axi_awready;
  endsequence
  sequence sRdWait;
    s_axi_rvalid && !s_axi_rready;
  endsequence
  chk_claim_cause: assert property (pciClaim |-> $past(pciAddrValid))
    else $error("claim without address phase");
  chk_valid_pair: assert property (pciClaim == localValid)
    else $error("claim and local valid differ");
  chk_low_pass: assert property (pciClaim |-> localAddr[15:0] == $past(pciAddr[15:0]))
    else $error("low address lines altered");
  chk_posted_mem: assert property (pciClaim && localPosted |->
    $past(pciAccessWrite && !pciAccessIo))
    else $error("posted outside memory write");
  chk_prefetch_rd: assert property (pciClaim && localPrefetch |-> $past(!pciAccessWrite))
    else $error("prefetch on a write");
  chk_burst_wr: assert property (pciClaim && localBurstOk |-> $past(pciAccessWrite))
    else $error("burst on a read");
  chk_aw_block: assert property (sAwTaken |=> !s_axi_awready)
    else $error("write address taken twice");
  chk_read_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_rdata_hold: assert property (sRdWait |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
endmodule
bind ptid_top ptid_checker chk (.*);
`default_nettype wire

// file: dv/ptid_pci_master.sv
// Model of the PCI master issuing address phases.
// Driven by task calls from the bench; lines change after clock edges.
`timescale 1ns/1ps
`default_nettype none
module ptid_pci_master (
  // Clock
  input wire logic sys_clk,
  // Address phase
  output logic pciAddrValid,
  output logic [31:0] pciAddr,
  output logic pciAccessIo,
  output logic pciAccessWrite
);
  initial begin
    pciAddrValid = 1'b0;
    pciAddr = 32'h0;
    pciAccessIo = 1'b0;
    pciAccessWrite = 1'b0;
  end
  // Between phases the lines are driven to the inverse, never a stale copy
  task issue(input logic [31:0] a, input logic io, input logic wr, input logic [1:0] gap);
    begin
      repeat (gap) @(posedge sys_clk);
      @(posedge sys_clk);
      pciAddrValid <= 1'b1;
      pciAddr <= a;
      pciAccessIo <= io;
      pciAccessWrite <= wr;
      @(posedge sys_clk);
      pciAddrValid <= 1'b0;
      pciAddr <= ~a;
      pciAccessIo <= ~io;
      pciAccessWrite <= ~wr;
    end
  endtask
endmodule
`default_nettype wire

// file: dv/ptid_top_test.sv
// Self-checking bench for the target image decoder.
// Drives the register bus and the PCI model; a monitor checks results.
`timescale 1ns/1ps
`default_nettype none
`include "ptid_defines.vh"
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin mismatches++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, a, e); end end
module ptid_top_test;
  logic sys_clk = 0, reset_n = 0;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0;
  logic [3:0] s_axi_wstrb = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, pciDisableStrap = 0, eeLoadDone = 0;
  logic eeLoaded0 = 0, eeSpace0 = 0, eeCfgBaseEn0 = 0, pciConfigSpace0 = 0;
  logic eeLoaded1 = 0, eeSpace1 = 0, eeCfgBaseEn1 = 0, pciConfigSpace1 = 0;
  logic [3:0] eeWindowSizeCode0 = 0, eeWindowSizeCode1 = 0, sz;
  logic [15:0] pciConfigBase0 = 0, pciConfigBase1 = 0, cb, msk;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp, localPortWidth;
  wire [31:0] s_axi_rdata, pciAddr, localAddr;
  wire pciAddrValid, pciAccessIo, pciAccessWrite, pciClaim, localValid, localImage;
  wire localBigEndian, localPrefetch, localBurstOk, localPosted;
  wire [3:0] localTransCode;
  int mismatches = 0, n_tests = 0, cyc = 0, sd;
  logic [42:0] expCl[$], ec;
  logic [33:0] expRd[$], er;
  logic [1:0] expB[$], eb;
  logic [31:0] ctl, adr, pa, misc;
  logic wrb;
  ptid_top DUT (.*);
  ptid_pci_master master (.*);
  initial forever #5 sys_clk = ~sys_clk;
  task complete_run;
    begin
      $display("Counts: %0d compares, %0d mismatches", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  // Bounded run: a hang counts as a failure
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 8000) begin
      mismatches++;
      complete_run;
    end
  end
  // Oldest note against each result; an unexpected one meets x
  always @(posedge sys_clk) begin
    if (localValid) begin
      ec = expCl.size() ? expCl.pop_front() : 'x;
      `CHK({localImage, localAddr, localTransCode, localPortWidth, localBigEndian,
        localPrefetch, localBurstOk, localPosted}, ec)
    end
    if (s_axi_rvalid && s_axi_rready) begin
      er = expRd.size() ? expRd.pop_front() : 'x;
      `CHK({s_axi_rresp, s_axi_rdata}, er)
    end
    if (s_axi_bvalid && s_axi_bready) begin
      eb = expB.size() ? expB.pop_front() : 'x;
      `CHK(s_axi_bresp, eb)
    end
  end
  task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e);
    logic aw, w;
    begin
      aw = 0;
      w = 0;
      expB.push_back(e);
      @(posedge sys_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hf;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1'($urandom);
      while (!(aw && w)) begin
        @(posedge sys_clk);
        if (s_axi_awready && !aw) begin
          aw = 1;
          s_axi_awvalid <= 0;
        end
        if (s_axi_wready && !w) begin
          w = 1;
          s_axi_wvalid <= 0;
        end
      end
      do begin
        @(posedge sys_clk);
        if (!s_axi_bready) s_axi_bready <= s_axi_bvalid;
      end while (!(s_axi_bvalid && s_axi_bready));
      s_axi_bready <= 0;
    end
  endtask
  task rd(input logic [11:0] a, input logic [33:0] e);
    begin
      expRd.push_back(e);
      @(posedge sys_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1'($urandom);
      do @(posedge sys_clk); while (!s_axi_arready);
      s_axi_arvalid <= 0;
      do begin
        @(posedge sys_clk);
        if (!s_axi_rready) s_axi_rready <= s_axi_rvalid;
      end while (!(s_axi_rvalid && s_axi_rready));
      s_axi_rready <= 0;
    end
  endtask
  // Both images get the same preload so their reads can share expectations
  task rst(input logic s, input logic ld);
    begin
      sz = 4'($urandom);
      cb = 16'($urandom);
      @(posedge sys_clk);
      reset_n <= 0;
      pciDisableStrap <= s;
      {eeLoaded0, eeLoaded1, eeCfgBaseEn0, eeCfgBaseEn1} <= {4{ld}};
      {eeSpace0, eeSpace1, pciConfigSpace0, pciConfigSpace1} <= {4{ld}};
      {eeWindowSizeCode0, eeWindowSizeCode1} <= {sz, sz};
      {pciConfigBase0, pciConfigBase1} <= {cb, cb};
      repeat (16) @(posedge sys_clk);
      reset_n <= 1;
      repeat (2) @(posedge sys_clk);
      eeLoadDone <= 1;
      @(posedge sys_clk);
      eeLoadDone <= 0;
    end
  endtask
  initial begin
    sd = $urandom(45288);
    rst(0, 0);
    for (logic [11:0] m = 0; m < 12'h20; m += 12'h10) begin
      rd(12'h100 + m, {`PTID_RESP_OKAY, 32'h0});
      rd(12'h104 + m, {`PTID_RESP_OKAY, 32'h0});
    end
    rd(12'h000, {`PTID_RESP_SLVERR, 32'h0});
    wr(12'h000, $urandom, `PTID_RESP_SLVERR);
    $display("Reset values and unmapped word done");
    for (int i = 0; i < 16; i++) begin
      ctl = ($urandom & 32'h8fc8fcc0) | 32'h80000000;
      ctl[27:24] = 4'(i);
      ctl[6] = i[0];
      ctl[11:10] = i[1:0];
      adr = $urandom;
      if (i == 3) adr[15:0] = adr[31:16];
      misc = $urandom;
      wr(12'h100, ctl, `PTID_RESP_OKAY);
      wr(12'h104, adr, `PTID_RESP_OKAY);
      wr(12'h120, misc, `PTID_RESP_OKAY);
      rd(12'h100, {`PTID_RESP_OKAY, ctl});
      msk = 16'hffff << i;
      pa = $urandom;
      pa[31:16] = (pa[31:16] & ~msk) | (adr[31:16] & msk);
      wrb = 1'($urandom);
      expCl.push_back({1'b0, (adr[15:0] & msk) | (pa[31:16] & ~msk), pa[15:0], ctl[15:12],
        ctl[11:10], misc[0] ^ ctl[19], ctl[23] & !wrb, ctl[22] & wrb,
        ctl[7] & wrb & !i[0]});
      master.issue(pa, i[0], wrb, i[1:0]);
      master.issue(pa, !i[0], wrb, 2'h0);
      master.issue(pa ^ (32'h1 << (16 + i)), i[0], wrb, 2'h0);
    end
    $display("Window sweep done");
    wr(12'h100, 32'h0, `PTID_RESP_OKAY);
    wr(12'h110, 32'h80000000, `PTID_RESP_OKAY);
    wr(12'h114, 32'h5a5ac3c3, `PTID_RESP_OKAY);
    expCl.push_back({1'b1, 32'hc3c31234, 6'h0, misc[0], 3'h0});
    master.issue(32'h5a5a1234, 1'b0, 1'b1, 2'h1);
    $display("Second image done");
    for (int s = 0; s < 2; s++) begin
      rst(s[0], 1);
      rd(12'h124, {`PTID_RESP_OKAY, 27'h0, 4'hf, s[0]});
      for (logic [11:0] m = 0; m < 12'h20; m += 12'h10) begin
        rd(12'h100 + m, {`PTID_RESP_OKAY, 4'h0, sz, 24'h40});
        rd(12'h104 + m, {`PTID_RESP_OKAY, cb, 16'h0});
        wr(12'h100 + m, 32'h80000000, `PTID_RESP_OKAY);
        wr(12'h104 + m, 32'h11112222, `PTID_RESP_OKAY);
        rd(12'h100 + m, s ? {`PTID_RESP_OKAY, 32'h80000000}
          : {`PTID_RESP_OKAY, 4'h8, sz, 24'h40});
        rd(12'h104 + m, {`PTID_RESP_OKAY, cb, 16'h2222});
      end
    end
    $display("Preload and strap done");
    repeat (4) @(posedge sys_clk);
    `CHK(expCl.size() + expRd.size() + expB.size() == 0, 1'b1)
    complete_run;
  end
endmodule
`default_nettype wire
